// ==== src/two_wire_master_cmd_status.v ====
`timescale 1ns/1ns
`include "two_wire_master_regs.vh"

// Summary of operation
// - Ten-bit bit selects 7-bit or 10-bit addressing.
// - Address bits 9-7 ignored in 7-bit mode.
// - Direction bit: zero transmit, one receive.
// - Current slot empties: next slot moves in.
// - Next-slot write lands in empty current slot.
// - Receive holding presents byte while ready set.
// - Status bit 16 shows master enabled.
// - Status bit 14 sets when stop accepted.
// - Status bit 13 sets on checksum mismatch.
// - Status bit 12 sets on SMBus timeout.
// - Status bit 11 sets on received alert.
// - Status bit 10 sets on arbitration loss.
// - Status bit 9 sets on data-phase NACK.
// - Status bit 8 sets on address-phase NACK.
// - Sticky flags clear only by writing one, by a software reset or by aresetn.
// - Status bit 5 shows two-wire bus quiet.
// - Status bit 4 shows no command pending.
// - Status bit 3 sets on successful completion.
// - Status bit 2 shows a free command slot.
// - Finished command clears current slot valid.
// - Transmit ready while holding empty and status bit 14 (stop) clear.
// - Receive ready while a byte waits.
module two_wire_master_cmd_status
#(
  parameter ADDR_W = 8
)
(
  input wire aclk,
  input wire aresetn,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire cmd_finish,
  input wire cmd_ok,
  input wire tx_take,
  input wire rx_strobe,
  input wire [7:0] rx_byte,
  input wire addr_nack_event,
  input wire data_nack_event,
  input wire timeout_event,
  input wire checksum_event,
  input wire stop_done,
  input wire sda_drive_high,
  input wire scl_in,
  input wire sda_in,
  input wire alert_in_n,
  output reg [31:0] current_command_slot,
  output reg [9:0] cmd_target_address,
  output reg cmd_ten_bit,
  output reg cmd_read,
  output reg [7:0] tx_byte,
  output reg tx_full,
  output reg rx_room,
  output reg master_on,
  output reg smbus_on,
  output reg stop_request,
  output reg soft_reset
);

  reg aw_have;
  reg w_have;
  reg [ADDR_W-1:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  reg [31:0] next_command_slot;
  reg [31:0] status_flags;
  reg [31:0] sticky;
  reg [7:0] rx_hold;
  reg rx_full;
  reg [7:0] rx_pend;
  reg rx_pend_full;
  reg bus_quiet;
  reg scl_s1;
  reg scl_s2;
  reg scl_s3;
  reg sda_s1;
  reg sda_s2;
  reg sda_s3;
  reg alert_s1;
  reg alert_s2;
  reg alert_s3;
  reg [31:0] next_cur;
  reg [31:0] next_nxt;
  reg [31:0] next_sticky;
  reg [31:0] next_status;
  reg [31:0] evt;
  reg [31:0] clr;
  reg [31:0] rd_data;
  reg rd_mapped;
  reg [7:0] next_rx_hold;
  reg next_rx_full;
  reg [7:0] next_rx_pend;
  reg next_rx_pend_full;

  wire do_write = aw_have && w_have && !s_axi_bvalid;
  wire [7:0] wr_ofs = aw_addr_q[7:0];
  wire [31:0] wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}},
    {8{w_strb_q[0]}}};
  wire wr_ctl = do_write && wr_ofs == `OFS_CONTROL;
  wire wr_cur = do_write && wr_ofs == `OFS_CUR_CMD;
  wire wr_next = do_write && wr_ofs == `OFS_NEXT_CMD;
  wire wr_tx = do_write && wr_ofs == `OFS_TX_HOLD && w_strb_q[0];
  wire wr_sclr = do_write && wr_ofs == `OFS_STATUS_CLEAR;
  wire [31:0] wbits = w_data_q & wmask;
  wire [31:0] merged_cur = (current_command_slot & ~wmask) | wbits;
  wire [31:0] merged_next = (next_command_slot & ~wmask) | wbits;
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire read_rx = ar_take && s_axi_araddr[7:0] == `OFS_RX_HOLD;
  wire scl_rise = scl_s2 && !scl_s3;
  wire start_seen = scl_s2 && scl_s3 && sda_s3 && !sda_s2;
  wire stop_seen = scl_s2 && scl_s3 && !sda_s3 && sda_s2;
  wire cur_valid = current_command_slot[`CMD_VALID];
  wire nxt_valid = next_command_slot[`CMD_VALID];

  // Register decode; write-only registers read as zero, holes answer SLVERR.
  always @*
  begin
    rd_data = 32'h00000000;
    rd_mapped = 1'b1;
    case (s_axi_araddr[7:0])
      `OFS_CONTROL: rd_data = 32'h00000000;
      `OFS_CUR_CMD: rd_data = current_command_slot;
      `OFS_NEXT_CMD: rd_data = next_command_slot;
      `OFS_RX_HOLD: rd_data = {24'h000000, rx_hold};
      `OFS_TX_HOLD: rd_data = 32'h00000000;
      `OFS_STATUS: rd_data = status_flags;
      `OFS_STATUS_CLEAR: rd_data = 32'h00000000;
      default: rd_mapped = 1'b0;
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr_q <= {ADDR_W{1'b0}};
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write)
      begin
        aw_have <= 1'b0;
        w_have <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (wr_ofs == `OFS_CONTROL || wr_ofs == `OFS_CUR_CMD ||
          wr_ofs == `OFS_NEXT_CMD || wr_ofs == `OFS_TX_HOLD ||
          wr_ofs == `OFS_STATUS_CLEAR)
          s_axi_bresp <= `RESP_OKAY;
        else
          s_axi_bresp <= `RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (ar_take)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_data;
        s_axi_rresp <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // A next-slot write that meets a finishing command keeps the queue order.
  always @*
  begin
    next_cur = current_command_slot;
    next_nxt = next_command_slot;
    if (cmd_finish)
      next_cur[`CMD_VALID] = 1'b0;
    if (wr_cur)
      next_cur = merged_cur;
    if (wr_next)
    begin
      if (next_cur[`CMD_VALID])
        next_nxt = merged_next;
      else if (nxt_valid)
      begin
        next_cur = next_command_slot;
        next_nxt = merged_next;
      end
      else
        next_cur = merged_next;
    end
    else if (!next_cur[`CMD_VALID] && nxt_valid)
    begin
      next_cur = next_command_slot;
      next_nxt[`CMD_VALID] = 1'b0;
    end
    if (soft_reset)
    begin
      next_cur = `CMD_RESET;
      next_nxt = `CMD_RESET;
    end
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      current_command_slot <= `CMD_RESET;
      next_command_slot <= `CMD_RESET;
      cmd_target_address <= 10'h000;
      cmd_ten_bit <= 1'b0;
      cmd_read <= 1'b0;
    end
    else
    begin
      current_command_slot <= next_cur;
      next_command_slot <= next_nxt;
      cmd_ten_bit <= next_cur[`CMD_TEN_BIT];
      cmd_read <= next_cur[`CMD_READ];
      if (next_cur[`CMD_TEN_BIT])
        cmd_target_address <= next_cur[`CMD_ADDR_HI+2:`CMD_ADDR_LO];
      else
        cmd_target_address <= {3'h0, next_cur[`CMD_ADDR_HI-1:`CMD_ADDR_LO]};
    end
  end

  // Software reset is honoured only while the master is on, as a disabled
  // unit must be enabled first.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      master_on <= 1'b0;
      smbus_on <= 1'b0;
      stop_request <= 1'b0;
      soft_reset <= 1'b0;
    end
    else
    begin
      stop_request <= wr_ctl && wbits[`CTL_STOP];
      soft_reset <= wr_ctl && wbits[`CTL_SOFT_RESET] && master_on;
      if (wr_ctl && wbits[`CTL_MASTER_OFF])
        master_on <= 1'b0;
      else if (wr_ctl && wbits[`CTL_MASTER_ON])
        master_on <= 1'b1;
      if (wr_ctl && wbits[`CTL_SMBUS_OFF])
        smbus_on <= 1'b0;
      else if (wr_ctl && wbits[`CTL_SMBUS_ON])
        smbus_on <= 1'b1;
    end
  end

  // A byte written while the holder is full and not being taken is dropped; software paces on
  // the transmit-space flag.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_byte <= 8'h00;
      tx_full <= 1'b0;
    end
    else if (soft_reset)
      tx_full <= 1'b0;
    else
    begin
      if (tx_take)
        tx_full <= 1'b0;
      if (wr_tx && (!tx_full || tx_take))
      begin
        tx_byte <= w_data_q[7:0];
        tx_full <= 1'b1;
      end
    end
  end

  always @*
  begin
    next_rx_hold = rx_hold;
    next_rx_full = rx_full;
    next_rx_pend = rx_pend;
    next_rx_pend_full = rx_pend_full;
    if (read_rx && rx_full)
    begin
      if (rx_pend_full)
      begin
        next_rx_hold = rx_pend;
        next_rx_pend_full = 1'b0;
      end
      else
        next_rx_full = 1'b0;
    end
    if (rx_strobe)
    begin
      if (!next_rx_full)
      begin
        next_rx_hold = rx_byte;
        next_rx_full = 1'b1;
      end
      else if (!next_rx_pend_full)
      begin
        next_rx_pend = rx_byte;
        next_rx_pend_full = 1'b1;
      end
    end
    if (soft_reset)
    begin
      next_rx_full = 1'b0;
      next_rx_pend_full = 1'b0;
    end
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_hold <= 8'h00;
      rx_full <= 1'b0;
      rx_pend <= 8'h00;
      rx_pend_full <= 1'b0;
      rx_room <= 1'b1;
    end
    else
    begin
      rx_hold <= next_rx_hold;
      rx_full <= next_rx_full;
      rx_pend <= next_rx_pend;
      rx_pend_full <= next_rx_pend_full;
      rx_room <= !next_rx_pend_full;
    end
  end

  // Pins cross through two flops; the third stage only serves edge finding.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_s3 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_s3 <= 1'b1;
      alert_s1 <= 1'b1;
      alert_s2 <= 1'b1;
      alert_s3 <= 1'b1;
      bus_quiet <= 1'b1;
    end
    else
    begin
      scl_s1 <= scl_in;
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
      alert_s1 <= alert_in_n;
      alert_s2 <= alert_s1;
      alert_s3 <= alert_s2;
      if (start_seen)
        bus_quiet <= 1'b0;
      else if (stop_seen)
        bus_quiet <= 1'b1;
    end
  end

  // Every flag that hardware sets wins over a status-clear write in the same cycle; a software reset clears all of them.
  always @*
  begin
    evt = 32'h00000000;
    evt[`ST_STOP] = stop_done;
    evt[`ST_CHECKSUM] = checksum_event;
    evt[`ST_TIMEOUT] = timeout_event;
    evt[`ST_ALERT] = alert_s3 && !alert_s2;
    evt[`ST_ARB_LOST] = scl_rise && sda_drive_high && !sda_s2 && cur_valid;
    evt[`ST_DATA_NACK] = data_nack_event;
    evt[`ST_ADDR_NACK] = addr_nack_event;
    evt[`ST_DONE] = cmd_finish && cmd_ok;
    clr = wr_sclr ? (wbits & `STICKY_MASK) : 32'h00000000;
    if (soft_reset)
      next_sticky = 32'h00000000;
    else
      next_sticky = ((sticky & ~clr) | evt) & `STICKY_MASK;
    next_status = sticky;
    next_status[`ST_MASTER_ON] = master_on;
    next_status[`ST_QUIET] = bus_quiet;
    next_status[`ST_IDLE] = !cur_valid && !nxt_valid;
    next_status[`ST_SLOT_FREE] = !(cur_valid && nxt_valid);
    next_status[`ST_TX_SPACE] = !tx_full && !sticky[`ST_STOP];
    next_status[`ST_RX_WAITING] = rx_full;
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sticky <= 32'h00000000;
      status_flags <= `STATUS_RESET;
    end
    else
    begin
      sticky <= next_sticky;
      status_flags <= next_status;
    end
  end

endmodule // two_wire_master_cmd_status

// ==== src/two_wire_master_regs.vh ====
`ifndef TWO_WIRE_MASTER_REGS_VH
`define TWO_WIRE_MASTER_REGS_VH
`define OFS_CONTROL 8'h00
`define OFS_CUR_CMD 8'h0C
`define OFS_NEXT_CMD 8'h10
`define OFS_RX_HOLD 8'h14
`define OFS_TX_HOLD 8'h18
`define OFS_STATUS 8'h1C
`define OFS_STATUS_CLEAR 8'h2C
`define CTL_MASTER_ON 0
`define CTL_MASTER_OFF 1
`define CTL_SMBUS_ON 4
`define CTL_SMBUS_OFF 5
`define CTL_SOFT_RESET 7
`define CTL_STOP 8
`define CMD_READ 0
`define CMD_ADDR_LO 1
`define CMD_ADDR_HI 8
`define CMD_TEN_BIT 11
`define CMD_VALID 15
`define ST_RX_WAITING 0
`define ST_TX_SPACE 1
`define ST_SLOT_FREE 2
`define ST_DONE 3
`define ST_IDLE 4
`define ST_QUIET 5
`define ST_ADDR_NACK 8
`define ST_DATA_NACK 9
`define ST_ARB_LOST 10
`define ST_ALERT 11
`define ST_TIMEOUT 12
`define ST_CHECKSUM 13
`define ST_STOP 14
`define ST_MASTER_ON 16
`define STICKY_MASK 32'h00007F08
`define STATUS_RESET 32'h00000002
`define CMD_RESET 32'h00000000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ==== testbench/twm_checker_sva.sv ====
`timescale 1ns/1ns
module twm_checker #(parameter ADDR_W = 8) (
  input wire aclk,
  input wire aresetn,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire [31:0] current_command_slot,
  input wire [9:0] cmd_target_address,
  input wire cmd_ten_bit,
  input wire cmd_read,
  input wire [7:0] tx_byte,
  input wire tx_full,
  input wire master_on,
  input wire stop_request,
  input wire soft_reset
);
  reg [ADDR_W-1:0] wa;
  reg [31:0] wd;
  reg [3:0] ws;
  // Address and data are latched apart, since the bus may take them on different edges.
  always @(posedge aclk)
  begin
    if (s_axi_awvalid && s_axi_awready)
      wa <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready)
      wd <= s_axi_wdata;
    if (s_axi_wvalid && s_axi_wready)
      ws <= s_axi_wstrb;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_ten;
    cmd_ten_bit == current_command_slot[11];
  endproperty
  a_ten: assert property (p_ten) else $error("ten-bit flag wrong");
  property p_addr;
    cmd_target_address ==
      {current_command_slot[10:8] & {3{cmd_ten_bit}}, current_command_slot[7:1]};
  endproperty
  a_addr: assert property (p_addr) else $error("target address wrong");
  property p_dir;
    cmd_read == current_command_slot[0];
  endproperty
  a_dir: assert property (p_dir) else $error("direction wrong");
  property p_next;
    $rose(s_axi_bvalid) && wa == 8'h10 && ws[1] && wd[15] |-> ##[0:1] current_command_slot[15];
  endproperty
  a_next: assert property (p_next) else $error("command not loaded");
  property p_tx;
    $rose(s_axi_bvalid) && wa == 8'h18 && ws[0] && !$past(tx_full)
      |-> ##[0:1] tx_full && tx_byte == wd[7:0];
  endproperty
  a_tx: assert property (p_tx) else $error("send byte not held");
  property p_on;
    $rose(s_axi_bvalid) && wa == 8'h00 && ws[0] && wd[1:0] == 2'h1 |-> ##[0:1] master_on;
  endproperty
  a_on: assert property (p_on) else $error("enable not taken");
  property p_stop;
    $rose(s_axi_bvalid) && wa == 8'h00 && ws[1] && wd[8] |-> ##[0:1] stop_request;
  endproperty
  a_stop: assert property (p_stop) else $error("stop not requested");
  property p_rd;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd: assert property (p_rd) else $error("read answer late");
  // The reset pulse is only owed while the master is already on.
  property p_soft;
    $rose(s_axi_bvalid) && wa == 8'h00 && ws[0] && wd[7] && master_on |-> soft_reset;
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset not pulsed");
  c_tx: cover property ($rose(tx_full));
  c_stop: cover property (stop_request);
  c_ten: cover property (current_command_slot[15] && cmd_ten_bit);
endmodule // twm_checker
bind two_wire_master_cmd_status twm_checker #(.ADDR_W(ADDR_W)) i_twm_checker (.*);

// ==== testbench/two_wire_far_side.sv ====
`timescale 1ns/1ns
module two_wire_far_side (
  input wire frame_go,
  input wire alert_go,
  output logic scl = 1'h1,
  output logic sda = 1'h1,
  output logic alert_n = 1'h1
);
  // Pull-ups hold the lines high and the clock stands still between frames.
  always @(posedge frame_go)
  begin
    sda = 1'h0;
    #62 scl = 1'h0;
    // Data is held low across clock rises, fighting a master that releases it.
    repeat (3)
    begin
      #63 scl = 1'h1;
      #62 scl = 1'h0;
    end
    #63 scl = 1'h1;
    #62 sda = 1'h1;
  end
  always @(posedge alert_go)
  begin
    alert_n = 1'h0;
    #250 alert_n = 1'h1;
  end
endmodule // two_wire_far_side

// ==== testbench/two_wire_master_cmd_status_test.sv ====
`timescale 1ns/1ns
module two_wire_master_cmd_status_test;
  logic aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, cmd_finish = 1'h0;
  logic cmd_ok = 1'h0, tx_take = 1'h0, rx_strobe = 1'h0, sda_drive_high = 1'h0;
  logic frame_go = 1'h0, alert_go = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0, rx_byte = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, d, e;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [4:0] ev = 5'h0;
  logic [1:0] r;
  int miscompares = 0, n_checks = 0, bt[5] = '{8, 9, 12, 13, 14};
  wire addr_nack_event = ev[0];
  wire data_nack_event = ev[1];
  wire timeout_event = ev[2];
  wire checksum_event = ev[3];
  wire stop_done = ev[4];
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata, current_command_slot;
  wire [9:0] cmd_target_address;
  wire [7:0] tx_byte;
  wire cmd_ten_bit, cmd_read, tx_full, rx_room, master_on, smbus_on, stop_request, soft_reset;
  wire scl_in, sda_in, alert_in_n;
  two_wire_master_cmd_status i_two_wire_master_cmd_status (.*);
  two_wire_far_side i_two_wire_far_side (.frame_go(frame_go), .alert_go(alert_go),
    .scl(scl_in), .sda(sda_in), .alert_n(alert_in_n));
  always #4 aclk = ~aclk;
  task close_out;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task settle;
    repeat (2) @(posedge aclk);
  endtask
  task wr(input [7:0] a, input [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'h0;
    end
    while (s_axi_bvalid !== 1'h1);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task rd(input [7:0] a);
    settle;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'h0;
    end
    while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  task rc(input [7:0] a, input [31:0] exp);
    rd(a);
    chk(d, exp);
  endtask
  task fin(input ok);
    @(posedge aclk);
    cmd_finish <= 1'h1;
    cmd_ok <= ok;
    @(posedge aclk);
    cmd_finish <= 1'h0;
  endtask
  task rxb(input [7:0] b);
    @(posedge aclk);
    rx_strobe <= 1'h1;
    rx_byte <= b;
    @(posedge aclk);
    rx_strobe <= 1'h0;
  endtask
  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    rc(8'h1C, 32'h36);
    rd(8'h30);
    chk(r, 2'h2);
    wr(8'h1C, 32'hFFFF);
    chk(r, 2'h2);
    wr(8'h00, 32'h1);
    rc(8'h1C, 32'h10036);
    // SMBus mode is switched off again before any ten-bit command is queued.
    wr(8'h00, 32'h10);
    chk(smbus_on, 1'h1);
    wr(8'h00, 32'h30);
    chk(smbus_on, 1'h0);
    wr(8'h10, 32'h8D4B);
    settle;
    chk({cmd_target_address, cmd_ten_bit, cmd_read}, {10'h2A5, 2'h3});
    rc(8'h1C, 32'h10026);
    wr(8'h10, 32'h872A);
    rc(8'h1C, 32'h10022);
    fin(1'h0);
    settle;
    chk({cmd_target_address, cmd_ten_bit, cmd_read}, {10'h015, 2'h0});
    rc(8'h0C, 32'h872A);
    rd(8'h10);
    chk(d[15], 1'h0);
    rc(8'h1C, 32'h10026);
    fin(1'h1);
    rc(8'h1C, 32'h1003E);
    wr(8'h2C, 32'h0);
    rc(8'h1C, 32'h1003E);
    wr(8'h2C, 32'h8);
    rc(8'h1C, 32'h10036);
    for (int i = 0; i < 5; i++)
    begin
      @(posedge aclk);
      ev <= 5'h1 << i;
      @(posedge aclk);
      ev <= 5'h0;
      e = (32'h10036 | (32'h1 << bt[i])) & ~((bt[i] == 14) ? 32'h2 : 32'h0);
      rc(8'h1C, e);
      wr(8'h2C, 32'h1 << bt[i]);
      rc(8'h1C, 32'h10036);
    end
    wr(8'h18, 32'hA5);
    rc(8'h1C, 32'h10034);
    wr(8'h18, 32'h5A);
    chk({tx_full, tx_byte}, 9'h1A5);
    @(posedge aclk);
    tx_take <= 1'h1;
    @(posedge aclk);
    tx_take <= 1'h0;
    rc(8'h1C, 32'h10036);
    rxb(8'h11);
    rc(8'h1C, 32'h10037);
    rxb(8'h22);
    rxb(8'h33);
    settle;
    chk(rx_room, 1'h0);
    rc(8'h14, 32'h11);
    rc(8'h14, 32'h22);
    rc(8'h1C, 32'h10036);
    wr(8'h10, 32'h8000);
    sda_drive_high <= 1'h1;
    frame_go <= 1'h1;
    alert_go <= 1'h1;
    repeat (20) @(posedge aclk);
    rd(8'h1C);
    chk(d[5], 1'h0);
    repeat (80) @(posedge aclk);
    rc(8'h1C, 32'h10C26);
    sda_drive_high <= 1'h0;
    wr(8'h00, 32'h80);
    rc(8'h1C, 32'h10036);
    wr(8'h00, 32'h100);
    wr(8'h00, 32'h2);
    rc(8'h1C, 32'h36);
    close_out;
  end
  initial
  begin
    #200000;
    miscompares++;
    close_out;
  end
endmodule // two_wire_master_cmd_status_test
